// ---- hdl/rbc_calendar_regs.v ----
// apb register block for the calendar and alarm value views of the clock calendar unit
`timescale 1ns/100ps
`include "rbc_defs.vh"

// Functional notes
// - value pointer 10 shows month and day view at its fixed bit positions
// - month tens digit is one bit, value 0 or 1
// - month ones digit is bits 11-8, bcd 0 to 9
// - day tens bits 5-4 range 0-3, day ones bits 3-0 range 0-9
// - value views accept writes only while the write unlock bit is 1
// - every unimplemented view bit reads zero
// - alarm pointer 01 shows weekday in bits 10-8, 0-6; 15-11 read zero
// - hour tens bits 5-4 range 0-2, hour ones bits 3-0
// - alarm pointer 00: minute tens bits 14-12 range 0-5, ones bits 11-8
// - seconds tens bits 6-4 range 0-5, seconds ones bits 3-0
// - digit bits are undefined after power-on until software loads them
// - write unlock bit decides whether time value view writes are taken
module rbc_calendar_regs (
   // clock and reset
   input  wire        I_CLK,
   input  wire        I_RST_N,
   // apb slave
   input  wire        I_PSEL,
   input  wire        I_PENABLE,
   input  wire        I_PWRITE,
   input  wire [11:0] I_PADDR,
   input  wire [31:0] I_PWDATA,
   output reg  [31:0] O_PRDATA,
   output reg         O_PREADY,
   output reg         O_PSLVERR
);
   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   reg rst_meta_n;
   reg rst_n;

   always @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   // ------------------------------------------------------------
   // control register: unlock bit and the two window pointers
   // ------------------------------------------------------------
   reg        value_write_unlock;
   reg [1:0]  value_window_pointer;
   reg [1:0]  alarm_window_pointer;

   wire       setup_phase  = I_PSEL && !I_PENABLE;
   wire       access_phase = I_PSEL && I_PENABLE;
   wire       hit_ctrl     = (I_PADDR == `RBC_OFF_CTRL);
   wire       hit_time     = (I_PADDR == `RBC_OFF_TIME_VIEW);
   wire       hit_alarm    = (I_PADDR == `RBC_OFF_ALARM_VIEW);
   wire       hit_ok       = (I_PADDR == `RBC_OFF_DIGIT_OK);
   wire       hit_any      = hit_ctrl | hit_time | hit_alarm | hit_ok;

   // slave answers in the first access cycle, so the write commits there;
   // ready stands for that one cycle only, so each write lands exactly once
   wire       wr_commit    = access_phase && I_PWRITE && O_PREADY;

   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         value_write_unlock   <= 1'b0;
         value_window_pointer <= 2'h0;
         alarm_window_pointer <= 2'h0;
      end else if (wr_commit && hit_ctrl) begin
         value_write_unlock   <= I_PWDATA[`RBC_CTRL_UNLOCK];
         value_window_pointer <= I_PWDATA[`RBC_CTRL_VPTR_LO +: 2];
         alarm_window_pointer <= I_PWDATA[`RBC_CTRL_APTR_LO +: 2];
      end
   end

   // ------------------------------------------------------------
   // view storage
   // ------------------------------------------------------------
   // locked views silently drop the write; the bus still completes cleanly
   wire        we_month_day = wr_commit && hit_time && value_write_unlock &&
                              (value_window_pointer == `RBC_VPTR_MONTH_DAY);
   wire        we_alarm_weekday_digit_hour = wr_commit && hit_alarm && value_write_unlock &&
                              (alarm_window_pointer == `RBC_APTR_ALARM_WEEKDAY_DIGIT_HOUR);
   wire        we_min_sec   = wr_commit && hit_alarm && value_write_unlock &&
                              (alarm_window_pointer == `RBC_APTR_MIN_SEC);
   wire [15:0] month_day;
   wire [15:0] alarm_weekday_digit_hour;
   wire [15:0] min_sec;
   wire [2:0]  digit_ok;

   rbc_view_reg #(.MASK(`RBC_MASK_MONTH_DAY)) u_month_day (
      .i_clk   (I_CLK),
      .i_we    (we_month_day),
      .i_wdata (I_PWDATA[15:0]),
      .o_rdata (month_day)
   );

   rbc_view_reg #(.MASK(`RBC_MASK_ALARM_WEEKDAY_DIGIT_HOUR)) u_alarm_weekday_digit_hour (
      .i_clk   (I_CLK),
      .i_we    (we_alarm_weekday_digit_hour),
      .i_wdata (I_PWDATA[15:0]),
      .o_rdata (alarm_weekday_digit_hour)
   );

   rbc_view_reg #(.MASK(`RBC_MASK_MIN_SEC)) u_min_sec (
      .i_clk   (I_CLK),
      .i_we    (we_min_sec),
      .i_wdata (I_PWDATA[15:0]),
      .o_rdata (min_sec)
   );

   // flags digit codes that software should never have loaded
   rbc_digit_check u_check (
      .i_month_day (month_day),
      .i_alarm_weekday_digit_hour (alarm_weekday_digit_hour),
      .i_min_sec   (min_sec),
      .o_ok        (digit_ok)
   );

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   reg [31:0] next_rdata;

   always @* begin
      next_rdata = 32'h0000_0000;
      if (hit_ctrl) begin
         next_rdata[`RBC_CTRL_UNLOCK]          = value_write_unlock;
         next_rdata[`RBC_CTRL_VPTR_LO +: 2]    = value_window_pointer;
         next_rdata[`RBC_CTRL_APTR_LO +: 2]    = alarm_window_pointer;
      end else if (hit_time) begin
         // other pointer codes select views not held here; they read zero
         if (value_window_pointer == `RBC_VPTR_MONTH_DAY) begin
            next_rdata[15:0] = month_day;
         end
      end else if (hit_alarm) begin
         case (alarm_window_pointer)
            `RBC_APTR_ALARM_WEEKDAY_DIGIT_HOUR: next_rdata[15:0] = alarm_weekday_digit_hour;
            `RBC_APTR_MIN_SEC:   next_rdata[15:0] = min_sec;
            default:             next_rdata[15:0] = 16'h0000;
         endcase
      end else if (hit_ok) begin
         next_rdata[2:0] = digit_ok;
      end
   end

   // ------------------------------------------------------------
   // apb answer: one wait-free access cycle
   // ------------------------------------------------------------
   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_PREADY  <= 1'b0;
         O_PRDATA  <= 32'h0000_0000;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY  <= setup_phase;
         O_PSLVERR <= setup_phase && !hit_any;
         if (setup_phase && !I_PWRITE) begin
            O_PRDATA <= next_rdata;
         end else begin
            O_PRDATA <= 32'h0000_0000;
         end
      end
   end
endmodule // rbc_calendar_regs

// ---- include/rbc_defs.vh ----
// register offsets, field positions and selector codes of the calendar and alarm value views
`ifndef RBC_DEFS_VH
`define RBC_DEFS_VH

// register byte offsets on the apb window
`define RBC_OFF_CTRL        12'h000
`define RBC_OFF_TIME_VIEW   12'h004
`define RBC_OFF_ALARM_VIEW  12'h008
`define RBC_OFF_DIGIT_OK    12'h00c

// control register fields
`define RBC_CTRL_UNLOCK     13
`define RBC_CTRL_VPTR_LO    8
`define RBC_CTRL_APTR_LO    0
`define RBC_CTRL_MASK       32'h0000_2303

// window pointer codes
`define RBC_VPTR_MONTH_DAY  2'h2
`define RBC_APTR_ALARM_WEEKDAY_DIGIT_HOUR  2'h1
`define RBC_APTR_MIN_SEC    2'h0

// implemented bits of each view
`define RBC_MASK_MONTH_DAY  16'h1f3f
`define RBC_MASK_ALARM_WEEKDAY_DIGIT_HOUR  16'h073f
`define RBC_MASK_MIN_SEC    16'h7f7f

// digit limits
`define RBC_MAX_MTH_TEN     4'h1
`define RBC_MAX_DAY_TEN     4'h3
`define RBC_MAX_ALARM_WEEKDAY_DIGIT        4'h6
`define RBC_MAX_HR_TEN      4'h2
`define RBC_MAX_MIN_TEN     4'h5
`define RBC_MAX_SEC_TEN     4'h5
`define RBC_MAX_ONES        4'h9

`endif

// ---- hdl/rbc_view_reg.v ----
// one 16-bit value view: masked storage with gated write, contents undefined until loaded
`timescale 1ns/100ps
module rbc_view_reg #(
   parameter [15:0] MASK = 16'hffff
) (
   // clock
   input  wire        i_clk,
   // write side
   input  wire        i_we,
   input  wire [15:0] i_wdata,
   // read side
   output wire [15:0] o_rdata
);
   reg [15:0] store;

   // no reset on purpose: digits are unknown until software loads them
   always @(posedge i_clk) begin
      if (i_we) begin
         store <= i_wdata & MASK;
      end
   end

   assign o_rdata = store & MASK;
endmodule // rbc_view_reg

// ---- hdl/rbc_digit_check.v ----
// checks that every bcd digit of a view lies in its documented range
`timescale 1ns/100ps
`include "rbc_defs.vh"
module rbc_digit_check (
   // view contents
   input  wire [15:0] i_month_day,
   input  wire [15:0] i_alarm_weekday_digit_hour,
   input  wire [15:0] i_min_sec,
   // one bit per view, high when all digits are legal
   output wire [2:0]  o_ok
);
   assign o_ok[0] = ({3'h0, i_month_day[12]} <= `RBC_MAX_MTH_TEN) &&
                    (i_month_day[11:8] <= `RBC_MAX_ONES) &&
                    ({2'h0, i_month_day[5:4]} <= `RBC_MAX_DAY_TEN) &&
                    (i_month_day[3:0] <= `RBC_MAX_ONES);
   assign o_ok[1] = ({1'h0, i_alarm_weekday_digit_hour[10:8]} <= `RBC_MAX_ALARM_WEEKDAY_DIGIT) &&
                    ({2'h0, i_alarm_weekday_digit_hour[5:4]} <= `RBC_MAX_HR_TEN) &&
                    (i_alarm_weekday_digit_hour[3:0] <= `RBC_MAX_ONES);
   assign o_ok[2] = ({1'h0, i_min_sec[14:12]} <= `RBC_MAX_MIN_TEN) &&
                    (i_min_sec[11:8] <= `RBC_MAX_ONES) &&
                    ({1'h0, i_min_sec[6:4]} <= `RBC_MAX_SEC_TEN) &&
                    (i_min_sec[3:0] <= `RBC_MAX_ONES);
endmodule // rbc_digit_check

// ---- dv/rbc_calendar_checker.sv ----
// assertion checker for the apb side of the calendar register block
`timescale 1ns/100ps
`include "rbc_defs.vh"
module rbc_calendar_checker (
   input logic        I_CLK,
   input logic        I_RST_N,
   input logic        I_PSEL,
   input logic        I_PENABLE,
   input logic        I_PWRITE,
   input logic [11:0] I_PADDR,
   input logic [31:0] I_PWDATA,
   input logic [31:0] O_PRDATA,
   input logic        O_PREADY,
   input logic        O_PSLVERR
);
   wire rd = O_PREADY && !I_PWRITE;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   // ----
   // assertions
   // ----
   chk_ready_after_setup: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
      else $error("no ready after setup");
   chk_ready_one_cycle: assert property (O_PREADY |=> !O_PREADY)
      else $error("ready held too long");
   chk_idle_data_zero: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
      else $error("read data outside access");
   chk_upper_half_zero: assert property (rd |-> O_PRDATA[31:16] == 16'h0)
      else $error("upper half not zero");
   chk_time_view_bits: assert property (rd && I_PADDR == `RBC_OFF_TIME_VIEW
      |-> (O_PRDATA & ~32'h1f3f) == 32'h0)
      else $error("time view unimplemented bit set");
   chk_alarm_view_bits: assert property (rd && I_PADDR == `RBC_OFF_ALARM_VIEW
      |-> (O_PRDATA & ~32'h7f7f) == 32'h0)
      else $error("alarm view unimplemented bit set");
   chk_ctrl_bits: assert property (rd && I_PADDR == `RBC_OFF_CTRL
      |-> (O_PRDATA & ~`RBC_CTRL_MASK) == 32'h0)
      else $error("control unimplemented bit set");
   // any address off the four word offsets, unaligned ones too, is unmapped
   chk_err_unmapped: assert property (O_PREADY |-> O_PSLVERR ==
      !(I_PADDR == `RBC_OFF_CTRL || I_PADDR == `RBC_OFF_TIME_VIEW ||
        I_PADDR == `RBC_OFF_ALARM_VIEW || I_PADDR == `RBC_OFF_DIGIT_OK))
      else $error("error response wrong");
   chk_err_reads_zero: assert property (rd && O_PSLVERR |-> O_PRDATA == 32'h0)
      else $error("error read not zero");
   cover property (rd && I_PADDR == `RBC_OFF_TIME_VIEW);
   cover property (O_PSLVERR);
   cover property (O_PREADY && I_PWRITE);
endmodule // rbc_calendar_checker

bind rbc_calendar_regs rbc_calendar_checker u_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
   .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
   .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR));

// ---- dv/testbench.sv ----
// self-checking bench for the calendar register block
`timescale 1ns/100ps
`include "rbc_defs.vh"
module testbench;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed, r;
   logic [32:0] expq[$];
   int          num_errors, comparisons;
   rbc_calendar_regs DUT (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task conclude();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [32:0] s, input logic [32:0] e);
      comparisons++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   // ----
   // apb master, one transfer, expectation queued for the monitor
   // ----
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
      int n;
      expq.push_back(e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge clk);
      if (pready !== 1'b1) begin
         num_errors++;
         conclude();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask
   // read data must also stand at zero on writes and on error responses
   always @(posedge clk) begin
      if (pready === 1'b1) chk({pslverr, prdata}, expq.pop_front());
   end
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      seed = 32'hb2f98204;
      num_errors = 0;
      comparisons = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(`RBC_OFF_CTRL, 32'h0);
      wr(`RBC_OFF_CTRL, 32'hffff_ffff);
      rd(`RBC_OFF_CTRL, `RBC_CTRL_MASK);
      rd(`RBC_OFF_TIME_VIEW, 32'h0);
      rd(`RBC_OFF_ALARM_VIEW, 32'h0);
      repeat (3) begin
         r = xs();
         wr(`RBC_OFF_CTRL, 32'h2201);
         wr(`RBC_OFF_TIME_VIEW, r);
         wr(`RBC_OFF_ALARM_VIEW, ~r);
         rd(`RBC_OFF_TIME_VIEW, r & `RBC_MASK_MONTH_DAY);
         rd(`RBC_OFF_ALARM_VIEW, ~r & `RBC_MASK_ALARM_WEEKDAY_DIGIT_HOUR);
         wr(`RBC_OFF_CTRL, 32'h2200);
         wr(`RBC_OFF_ALARM_VIEW, r);
         rd(`RBC_OFF_ALARM_VIEW, r & `RBC_MASK_MIN_SEC);
      end
      wr(`RBC_OFF_TIME_VIEW, 32'h1231);
      wr(`RBC_OFF_ALARM_VIEW, 32'h5959);
      wr(`RBC_OFF_CTRL, 32'h2201);
      wr(`RBC_OFF_ALARM_VIEW, 32'h0623);
      rd(`RBC_OFF_DIGIT_OK, 32'h7);
      wr(`RBC_OFF_TIME_VIEW, 32'h0a00);
      rd(`RBC_OFF_DIGIT_OK, 32'h6);
      wr(`RBC_OFF_TIME_VIEW, 32'h0815);
      // lock, then try to overwrite both views
      wr(`RBC_OFF_CTRL, 32'h0201);
      wr(`RBC_OFF_TIME_VIEW, 32'h0104);
      wr(`RBC_OFF_ALARM_VIEW, 32'h0111);
      rd(`RBC_OFF_TIME_VIEW, 32'h0815);
      rd(`RBC_OFF_ALARM_VIEW, 32'h0623);
      wr(`RBC_OFF_CTRL, 32'h0200);
      wr(`RBC_OFF_ALARM_VIEW, 32'h0111);
      rd(`RBC_OFF_ALARM_VIEW, 32'h5959);
      // unlocked, but the value pointer selects a view that is not held here
      wr(`RBC_OFF_CTRL, 32'h2300);
      wr(`RBC_OFF_TIME_VIEW, 32'h0104);
      rd(`RBC_OFF_TIME_VIEW, 32'h0);
      wr(`RBC_OFF_CTRL, 32'h2200);
      rd(`RBC_OFF_TIME_VIEW, 32'h0815);
      apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
      apb(1'b1, 12'h020, r, {1'b1, 32'h0});
      conclude();
   end
endmodule // testbench
